// ---- core/cas_alarm_status.sv ----
// per-channel alarm status register with its detectors
`timescale 1ns/1ps
`include "cas_consts.svh"
module cas_alarm_status #(
    parameter int FIFO_DEPTH = 32,
    parameter int DMO_PERIODS = `CAS_DMO_PERIODS
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire cas_pkg::cas_rate_e rate_mode,
    input wire logic tx_clk_en,
    input wire logic transmit_line_pair,
    input wire logic rx_bit_en,
    input wire logic rx_pulse,
    input wire logic rx_amplitude_low,
    input wire logic ref_tick,
    input wire logic rec_tick,
    input wire logic [5:0] fifo_fill,
    input wire logic prbs_enable,
    input wire logic prbs_in_sync,
    input wire logic [7:0] host_addr,
    input wire logic host_rd,
    input wire logic host_wr,
    output logic [7:0] host_rdata,
    output logic [7:0] channel_alarm_status,
    output logic [1:0] change_flags
);
    // ------------------------------------------------------------
    // parameter checks
    // ------------------------------------------------------------
    if (FIFO_DEPTH != 16 && FIFO_DEPTH != 32) begin : g_bad_depth
        $error("fifo depth must be 16 or 32");
    end
    if (DMO_PERIODS < 2 || DMO_PERIODS > 255) begin : g_bad_dmo
        $error("driver monitor count out of range");
    end

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [6:0] s1_r, s2_r;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s1_r <= 7'h00;
            s2_r <= 7'h00;
        end else begin
            s1_r <= {prbs_in_sync, prbs_enable, rx_amplitude_low,
                     rx_pulse, transmit_line_pair, rec_tick, ref_tick};
            s2_r <= s1_r;
        end
    end
    logic ref_s, rec_s, txp_s, rxp_s, amp_s, pen_s, psy_s;
    assign {psy_s, pen_s, amp_s, rxp_s, txp_s, rec_s, ref_s} = s2_r;

    // ------------------------------------------------------------
    // driver output monitor
    // ------------------------------------------------------------
    logic txp_d_r;
    logic [7:0] dmo_cnt_r;
    logic dmo_r;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            txp_d_r <= 1'b0;
            dmo_cnt_r <= 8'h00;
            dmo_r <= 1'b0;
        end else begin
            txp_d_r <= txp_s;
            if (txp_s != txp_d_r) begin
                dmo_cnt_r <= 8'h00;
                dmo_r <= 1'b0;
            end else if (tx_clk_en) begin
                if (dmo_cnt_r == 8'(DMO_PERIODS - 1))
                    dmo_r <= 1'b1;
                else
                    dmo_cnt_r <= dmo_cnt_r + 8'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // pulse absence and analog loss
    // ------------------------------------------------------------
    logic [7:0] abs_cnt_r;
    logic dlos_r, alos_r;
    logic [7:0] abs_limit;
    assign abs_limit = (rate_mode == cas_pkg::cas_rate_e3) ?
        8'(`CAS_E3_ABS_BITS) : 8'(`CAS_DS3_ABS_BITS);
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            abs_cnt_r <= 8'h00;
            dlos_r <= 1'b0;
        end else if (rxp_s) begin
            abs_cnt_r <= 8'h00;
            dlos_r <= 1'b0;
        end else if (rx_bit_en) begin
            if (abs_cnt_r == abs_limit - 8'h01)
                dlos_r <= 1'b1;
            else
                abs_cnt_r <= abs_cnt_r + 8'h01;
        end
    end
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst)
            alos_r <= 1'b0;
        else if (rate_mode == cas_pkg::cas_rate_e3)
            alos_r <= amp_s & dlos_r;
        else
            alos_r <= amp_s;
    end

    // ------------------------------------------------------------
    // lock monitor: compare tick counts over a window
    // ------------------------------------------------------------
    // window closes after a fixed count of reference edges
    // recovered count saturates so a runaway clock cannot wrap
    logic [11:0] ref_cnt_r, rec_cnt_r;
    logic ref_d_r, rec_d_r, rlol_r;
    logic [11:0] diff;
    assign diff = (rec_cnt_r > ref_cnt_r) ? rec_cnt_r - ref_cnt_r :
        ref_cnt_r - rec_cnt_r;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ref_cnt_r <= 12'h000;
            rec_cnt_r <= 12'h000;
            ref_d_r <= 1'b0;
            rec_d_r <= 1'b0;
            rlol_r <= 1'b0;
        end else begin
            ref_d_r <= ref_s;
            rec_d_r <= rec_s;
            if (ref_cnt_r == 12'(`CAS_LOCK_WINDOW)) begin
                rlol_r <= diff > 12'(`CAS_LOCK_TOL);
                ref_cnt_r <= 12'h000;
                rec_cnt_r <= 12'h000;
            end else begin
                if (ref_s & ~ref_d_r)
                    ref_cnt_r <= ref_cnt_r + 12'h001;
                if (rec_s & ~rec_d_r & (rec_cnt_r != 12'hfff))
                    rec_cnt_r <= rec_cnt_r + 12'h001;
            end
        end
    end

    // ------------------------------------------------------------
    // status assembly and change flags
    // ------------------------------------------------------------
    logic fl;
    assign fl = (fifo_fill <= 6'(`CAS_FIFO_MARGIN)) ||
        (fifo_fill >= 6'(FIFO_DEPTH - `CAS_FIFO_MARGIN));
    logic [7:0] status_nxt;
    always_comb begin
        status_nxt = `CAS_RESET_VALUE;
        status_nxt[`CAS_BIT_DMO] = dmo_r;
        status_nxt[`CAS_BIT_RLOS] = dlos_r | alos_r;
        status_nxt[`CAS_BIT_RLOL] = rlol_r;
        status_nxt[`CAS_BIT_FL] = fl;
        status_nxt[`CAS_BIT_ALOS] = alos_r;
        status_nxt[`CAS_BIT_DLOS] = dlos_r;
        status_nxt[`CAS_BIT_PSL] = pen_s & ~psy_s;
    end

    // ------------------------------------------------------------
    // host address decode
    // ------------------------------------------------------------
    function automatic logic addr_is(input logic [7:0] addr,
        input logic [7:0] target);
        addr_is = addr == target;
    endfunction
    logic rd_hit;
    assign rd_hit = host_rd && addr_is(host_addr, `CAS_ALARM_STATUS_ADDR);
    logic chg_rd;
    assign chg_rd = host_rd &&
        addr_is(host_addr, `CAS_ALARM_STATUS_ADDR - 8'h01);
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst)
            channel_alarm_status <= `CAS_RESET_VALUE;
        else
            channel_alarm_status <= status_nxt;
    end
    logic [1:0] chg_set;
    assign chg_set[`CAS_CHG_RLOS] = status_nxt[`CAS_BIT_RLOS] !=
        channel_alarm_status[`CAS_BIT_RLOS];
    assign chg_set[`CAS_CHG_FL] = status_nxt[`CAS_BIT_FL] !=
        channel_alarm_status[`CAS_BIT_FL];
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst)
            change_flags <= 2'h0;
        else
            change_flags <= chg_set |
                (chg_rd ? 2'h0 : change_flags);
    end
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst)
            host_rdata <= 8'h00;
        else if (rd_hit)
            host_rdata <= channel_alarm_status;
        else if (chg_rd)
            host_rdata <= {6'h00, change_flags};
        else
            host_rdata <= 8'h00;
    end
    // writes reach no storage; the strobe is only sunk here
    logic wr_ignored;
    assign wr_ignored = host_wr;
endmodule

// ---- core/cas_consts.svh ----
// constants for the channel alarm status block
`ifndef CAS_CONSTS_SVH
`define CAS_CONSTS_SVH
`define CAS_ALARM_STATUS_ADDR 8'h03
`define CAS_RESET_VALUE 8'h00
`define CAS_BIT_DMO 0
`define CAS_BIT_RLOS 1
`define CAS_BIT_RLOL 2
`define CAS_BIT_FL 3
`define CAS_BIT_ALOS 4
`define CAS_BIT_DLOS 5
`define CAS_BIT_PSL 6
`define CAS_CHG_RLOS 0
`define CAS_CHG_FL 1
`define CAS_DMO_PERIODS 128
`define CAS_E3_ABS_BITS 10
`define CAS_DS3_ABS_BITS 100
`define CAS_LOCK_WINDOW 2000
`define CAS_LOCK_TOL 10
`define CAS_FIFO_MARGIN 2
`endif

// ---- core/cas_pkg.sv ----
// types for the channel alarm status block
package cas_pkg;
    typedef enum logic [1:0] {
        cas_rate_e3,
        cas_rate_ds3,
        cas_rate_sts1
    } cas_rate_e;
endpackage

// ---- tb/cas_alarm_status_checker.sv ----
// checker for the channel alarm status block
`timescale 1ns/1ps
module cas_alarm_status_checker #(
    parameter int FIFO_DEPTH = 32
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire cas_pkg::cas_rate_e rate_mode,
    input wire logic transmit_line_pair,
    input wire logic [5:0] fifo_fill,
    input wire logic prbs_enable,
    input wire logic prbs_in_sync,
    input wire logic [7:0] host_addr,
    input wire logic host_rd,
    input wire logic [7:0] host_rdata,
    input wire logic [7:0] channel_alarm_status,
    input wire logic [1:0] change_flags
);
    // ------------------------------------------
    // properties
    // ------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    wire [7:0] s = channel_alarm_status;
    wire lim = fifo_fill <= 6'h02 || fifo_fill >= FIFO_DEPTH - 2;
    property p_top; s[7] == 1'b0; endproperty
    a_top: assert property (p_top) else $error("top bit set");
    property p_idle; !host_rd |=> host_rdata == 8'h00; endproperty
    a_idle: assert property (p_idle) else $error("rdata idle");
    property p_unm;
        host_rd && host_addr > 8'h03 |=> host_rdata == 8'h00;
    endproperty
    a_unm: assert property (p_unm) else $error("unmapped");
    property p_dmo; $changed(transmit_line_pair) |-> ##[1:6] !s[0]; endproperty
    a_dmo: assert property (p_dmo) else $error("dmo clear");
    property p_los; $rose(s[5] | s[4]) |-> ##[0:2] s[1]; endproperty
    a_los: assert property (p_los) else $error("rx loss");
    property p_fl; lim [*3] |-> s[3]; endproperty
    a_fl: assert property (p_fl) else $error("fifo set");
    property p_nfl; !lim [*3] |-> !s[3]; endproperty
    a_nfl: assert property (p_nfl) else $error("fifo clr");
    property p_e3;
        (rate_mode == cas_pkg::cas_rate_e3 && !s[5]) [*4] |-> !s[4];
    endproperty
    a_e3: assert property (p_e3) else $error("e3 analog");
    property p_ps; (prbs_enable && !prbs_in_sync) [*5] |-> s[6]; endproperty
    a_ps: assert property (p_ps) else $error("prbs set");
    property p_cf; $changed(s[1]) |-> ##[0:2] change_flags[0]; endproperty
    a_cf: assert property (p_cf) else $error("loss change");
    property p_cff; $changed(s[3]) |-> ##[0:2] change_flags[1]; endproperty
    a_cff: assert property (p_cff) else $error("fifo change");
    c_dmo: cover property (s[0]);
    c_lol: cover property (s[2]);
    c_cff: cover property (change_flags[1]);
endmodule
bind cas_alarm_status cas_alarm_status_checker #(
    .FIFO_DEPTH(FIFO_DEPTH)) i_cas_alarm_status_checker (.*);

// ---- tb/cas_alarm_status_tb.sv ----
// testbench for the channel alarm status block
`timescale 1ns/1ps
module cas_alarm_status_tb;
    logic clk, sys_rst, tx_clk_en, transmit_line_pair, rx_bit_en, rx_pulse;
    logic rx_amplitude_low, ref_tick, rec_tick, prbs_enable, prbs_in_sync;
    logic host_rd, host_wr, lose;
    logic [5:0] fifo_fill;
    logic [7:0] host_addr, host_rdata, channel_alarm_status;
    logic [1:0] change_flags;
    logic [1:0] tn = 2'h0;
    cas_pkg::cas_rate_e rate_mode;
    cas_pkg::cas_rate_e md[3] = '{cas_pkg::cas_rate_e3,
        cas_pkg::cas_rate_ds3, cas_pkg::cas_rate_sts1};
    int bad_count, checks, n;
    cas_alarm_status #(.DMO_PERIODS(8)) i_cas_alarm_status (.*);
    // ------------------------------------------
    // clock, ticks and tasks
    // ------------------------------------------
    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) tn <= tn + 2'h1;
    assign ref_tick = tn[1];
    assign rec_tick = lose ? tn[0] : tn[1];
    task automatic chk(input string n, input logic [7:0] e, g);
        checks++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic st(input int n, input logic [7:0] e);
        cyc(n);
        chk("status", e, channel_alarm_status);
    endtask
    task automatic rd(input logic [7:0] a, e);
        host_addr = a;
        host_rd = 1;
        cyc(1);
        host_rd = 0;
        chk("rdata", e, host_rdata);
        cyc(1);
    endtask
    task automatic end_sim;
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        #600000;
        bad_count++;
        end_sim;
    end
    // ------------------------------------------
    // tests
    // ------------------------------------------
    initial begin
        {sys_rst, tx_clk_en, transmit_line_pair, rx_bit_en, rx_pulse} = 5'h10;
        {rx_amplitude_low, prbs_enable, prbs_in_sync, host_rd, host_wr} = 0;
        {lose, host_addr, fifo_fill} = {9'h000, 6'h10};
        rate_mode = cas_pkg::cas_rate_ds3;
        cyc(3);
        sys_rst = 0;
        rd(8'h03, 8'h00);
        host_wr = 1;
        rd(8'h03, 8'h00);
        host_wr = 0;
        rd(8'h10, 8'h00);
        tx_clk_en = 1;
        st(4, 8'h00);
        st(12, 8'h01);
        transmit_line_pair = 1;
        st(5, 8'h00);
        tx_clk_en = 0;
        rx_bit_en = 1;
        foreach (md[i]) begin
            rate_mode = md[i];
            rx_pulse = 0;
            n = md[i] == cas_pkg::cas_rate_e3 ? 8 : 90;
            st(n, 8'h00);
            st(n == 8 ? 8 : 20, 8'h22);
            rd(8'h02, 8'h01);
            rx_pulse = 1;
            st(5, 8'h00);
            rd(8'h02, 8'h01);
        end
        rd(8'h02, 8'h00);
        {rate_mode, rx_amplitude_low} = {cas_pkg::cas_rate_e3, 1'b1};
        st(6, 8'h00);
        rate_mode = cas_pkg::cas_rate_ds3;
        st(6, 8'h12);
        rx_amplitude_low = 0;
        st(6, 8'h00);
        rd(8'h02, 8'h01);
        foreach (md[i]) begin
            fifo_fill = i == 0 ? 6'h02 : i == 1 ? 6'h1e : 6'h20;
            st(3, 8'h08);
            fifo_fill = i == 0 ? 6'h03 : i == 1 ? 6'h1d : 6'h10;
            st(3, 8'h00);
        end
        chk("flags", 8'h02, {6'h00, change_flags});
        rd(8'h02, 8'h02);
        prbs_enable = 1;
        st(5, 8'h40);
        prbs_in_sync = 1;
        st(5, 8'h00);
        lose = 1;
        st(20000, 8'h04);
        rd(8'h03, 8'h04);
        lose = 0;
        st(20000, 8'h00);
        end_sim;
    end
endmodule
